/* common/cel_defines.vh */
// Register offsets, field positions and reset values of the event,
// level, regulator and preamplifier register slice.
// Assumes inclusion by the bare name from the design files.
//
// Functional notes
// - Jack change flag in event bit 7, resets 0, write 1 clears it.
// - Jack event drives low interrupt output only while mask bit 7 is 0.
// - Threshold flag in event bit 0, routed to interrupt while mask bit 0 is 0.
// - Pad voltage bit 0: 0 means 2.5-3.6 V, 1 means 1.5-2.5 V; resets 0.
// - Regulator bit 7 high makes core regulator active; bias must be on first.
// - Regulator level bits 5:4: 1.05, 1.10, 1.20, 1.40 V; resets 00.
// - Detector enables bits 3:0, one channel each, 1 enables, reset 0.
// - Threshold bits 6:0 set anti-clip level (x+1)/128 full scale; resets 0x7F.
// - Preamp control bit 7 enables the preamplifier; resets 0.
// - Preamp control bit 6 mutes the preamplifier; resets 1.
// - Preamp gain bits 2:0 in 6 dB steps from -6 to 36 dB; resets 001.
// - Preamp source bits 1:0: differential, positive, negative, reserved.
`ifndef CEL_DEFINES_VH
`define CEL_DEFINES_VH

// ============================================================
// Register offsets
`define CEL_ADDR_DET_EN      8'h50
`define CEL_ADDR_DET_THR     8'h51
`define CEL_ADDR_P1_SW       8'hB4
`define CEL_ADDR_P1_GAIN     8'hB5
`define CEL_ADDR_P1_SRC      8'hB7
`define CEL_ADDR_P2_SW       8'hB8
`define CEL_ADDR_P2_GAIN     8'hB9
`define CEL_ADDR_P2_SRC      8'hBB
`define CEL_ADDR_PAD         8'hE0
`define CEL_ADDR_REG         8'hE1
`define CEL_ADDR_FLAGS       8'hED
`define CEL_ADDR_MASKS       8'hEE

// ============================================================
// Field positions
`define CEL_JACK_BIT         7
`define CEL_THR_BIT          0
`define CEL_PAD_BIT          0
`define CEL_REG_EN_BIT       7
`define CEL_REG_LVL_HI       5
`define CEL_REG_LVL_LO       4
`define CEL_DET_EN_HI        3
`define CEL_THR_HI           6
`define CEL_P_EN_BIT         7
`define CEL_P_MUTE_BIT       6
`define CEL_GAIN_HI          2
`define CEL_SRC_HI           1

// ============================================================
// Reset values
`define CEL_RST_DET_EN       4'h0
`define CEL_RST_THR          7'h7F
`define CEL_RST_GAIN         3'h1
`define CEL_RST_SRC          2'h0
`define CEL_RST_PAD          1'h0
`define CEL_RST_REG_LVL      2'h0
`define CEL_RST_EN           1'h0
`define CEL_RST_MUTE         1'h1
`define CEL_RST_FLAG         1'h0
`define CEL_RST_MASK         1'h0
`define CEL_RST_BYTE         8'h00

`endif

/* hdl/cel_level_cmp.v */
// Level comparator for the four detector channels.
// Assumes 7-bit channel magnitudes synchronous to mclk.
`timescale 1ns/1ps
module cel_level_cmp (
  input  wire [3:0]  chan_en,
  input  wire [6:0]  threshold,
  input  wire [27:0] chan_level,
  output reg         crossing
);
  integer i;
  // ============================================================
  // Any enabled channel above threshold
  always @* begin
    crossing = 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      if (chan_en[i] && (chan_level[i*7 +: 7] > threshold)) begin
        crossing = 1'b1;
      end
    end
  end
endmodule // cel_level_cmp

/* hdl/cel_regs.v */
// Event, level detector, regulator and preamplifier register slice.
// Assumes a byte-wide control port already decoded from the serial
// control interface: one-cycle write and read strobes on mclk.
`timescale 1ns/1ps
`include "cel_defines.vh"
module cel_regs (
  input  wire        mclk,
  input  wire        reset,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata_r,
  input  wire        jack_change,
  input  wire [27:0] chan_level,
  output reg         interrupt_out_low_r,
  output reg  [3:0]  det_chan_en_r,
  output reg  [6:0]  det_threshold_r,
  output reg         pad_low_range_r,
  output reg         core_reg_en_r,
  output reg  [1:0]  core_reg_level_r,
  output reg         p1_en_r,
  output reg         p1_mute_r,
  output reg  [2:0]  p1_gain_r,
  output reg  [1:0]  p1_src_r,
  output reg         p2_en_r,
  output reg         p2_mute_r,
  output reg  [2:0]  p2_gain_r,
  output reg  [1:0]  p2_src_r
);

  // ============================================================
  // Internal state
  reg        jack_flag_r;
  reg        thr_flag_r;
  reg        jack_mask_r;
  reg        thr_mask_r;
  reg        jack_flag_nxt;
  reg        thr_flag_nxt;
  reg [7:0]  rdata_nxt;
  wire       crossing;
  wire       wr_flags;

  // Write-one-to-clear strobe per bit of the event register
  function w1c;
    input       wr;
    input [7:0] addr;
    input       bit_val;
    begin
      w1c = wr && (addr == `CEL_ADDR_FLAGS) && bit_val;
    end
  endfunction

  assign wr_flags = reg_wr && (reg_addr == `CEL_ADDR_FLAGS);

  cel_level_cmp u_cmp (
    .chan_en    (det_chan_en_r),
    .threshold  (det_threshold_r),
    .chan_level (chan_level),
    .crossing   (crossing)
  );

  // ============================================================
  // Sticky flags; a new event beats a clear in the same cycle
  always @* begin
    jack_flag_nxt = jack_flag_r;
    thr_flag_nxt  = thr_flag_r;
    if (w1c(reg_wr, reg_addr, reg_wdata[`CEL_JACK_BIT])) begin
      jack_flag_nxt = 1'b0;
    end
    if (w1c(reg_wr, reg_addr, reg_wdata[`CEL_THR_BIT])) begin
      thr_flag_nxt = 1'b0;
    end
    if (jack_change) begin
      jack_flag_nxt = 1'b1;
    end
    if (crossing) begin
      thr_flag_nxt = 1'b1;
    end
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      jack_flag_r <= `CEL_RST_FLAG;
      thr_flag_r  <= `CEL_RST_FLAG;
    end else begin
      jack_flag_r <= jack_flag_nxt;
      thr_flag_r  <= thr_flag_nxt;
    end
  end

  // ============================================================
  // Interrupt pin; registered from next flag state to save a cycle
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      interrupt_out_low_r <= 1'b1;
    end else begin
      interrupt_out_low_r <= ~((jack_flag_nxt & ~jack_mask_r)
                             | (thr_flag_nxt & ~thr_mask_r));
    end
  end

  // ============================================================
  // Control register writes
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      det_chan_en_r    <= `CEL_RST_DET_EN;
      det_threshold_r  <= `CEL_RST_THR;
      pad_low_range_r  <= `CEL_RST_PAD;
      core_reg_en_r    <= `CEL_RST_EN;
      core_reg_level_r <= `CEL_RST_REG_LVL;
      p1_en_r          <= `CEL_RST_EN;
      p1_mute_r        <= `CEL_RST_MUTE;
      p1_gain_r        <= `CEL_RST_GAIN;
      p1_src_r         <= `CEL_RST_SRC;
      p2_en_r          <= `CEL_RST_EN;
      p2_mute_r        <= `CEL_RST_MUTE;
      p2_gain_r        <= `CEL_RST_GAIN;
      p2_src_r         <= `CEL_RST_SRC;
      jack_mask_r      <= `CEL_RST_MASK;
      thr_mask_r       <= `CEL_RST_MASK;
    end else if (reg_wr) begin
      if (reg_addr == `CEL_ADDR_DET_EN) begin
        det_chan_en_r <= reg_wdata[`CEL_DET_EN_HI:0];
      end else if (reg_addr == `CEL_ADDR_DET_THR) begin
        det_threshold_r <= reg_wdata[`CEL_THR_HI:0];
      end else if (reg_addr == `CEL_ADDR_PAD) begin
        pad_low_range_r <= reg_wdata[`CEL_PAD_BIT];
      end else if (reg_addr == `CEL_ADDR_REG) begin
        // Bias must already be on; this block cannot check it
        core_reg_en_r    <= reg_wdata[`CEL_REG_EN_BIT];
        core_reg_level_r <= reg_wdata[`CEL_REG_LVL_HI:`CEL_REG_LVL_LO];
      end else if (reg_addr == `CEL_ADDR_P1_SW) begin
        p1_en_r   <= reg_wdata[`CEL_P_EN_BIT];
        p1_mute_r <= reg_wdata[`CEL_P_MUTE_BIT];
      end else if (reg_addr == `CEL_ADDR_P1_GAIN) begin
        p1_gain_r <= reg_wdata[`CEL_GAIN_HI:0];
      end else if (reg_addr == `CEL_ADDR_P1_SRC) begin
        p1_src_r <= reg_wdata[`CEL_SRC_HI:0];
      end else if (reg_addr == `CEL_ADDR_P2_SW) begin
        p2_en_r   <= reg_wdata[`CEL_P_EN_BIT];
        p2_mute_r <= reg_wdata[`CEL_P_MUTE_BIT];
      end else if (reg_addr == `CEL_ADDR_P2_GAIN) begin
        p2_gain_r <= reg_wdata[`CEL_GAIN_HI:0];
      end else if (reg_addr == `CEL_ADDR_P2_SRC) begin
        p2_src_r <= reg_wdata[`CEL_SRC_HI:0];
      end else if (reg_addr == `CEL_ADDR_MASKS) begin
        jack_mask_r <= reg_wdata[`CEL_JACK_BIT];
        thr_mask_r  <= reg_wdata[`CEL_THR_BIT];
      end
    end
  end

  // ============================================================
  // Read mux; reserved bits and unmapped addresses read zero
  always @* begin
    rdata_nxt = `CEL_RST_BYTE;
    if (reg_addr == `CEL_ADDR_DET_EN) begin
      rdata_nxt[`CEL_DET_EN_HI:0] = det_chan_en_r;
    end else if (reg_addr == `CEL_ADDR_DET_THR) begin
      rdata_nxt[`CEL_THR_HI:0] = det_threshold_r;
    end else if (reg_addr == `CEL_ADDR_PAD) begin
      rdata_nxt[`CEL_PAD_BIT] = pad_low_range_r;
    end else if (reg_addr == `CEL_ADDR_REG) begin
      rdata_nxt[`CEL_REG_EN_BIT] = core_reg_en_r;
      rdata_nxt[`CEL_REG_LVL_HI:`CEL_REG_LVL_LO] = core_reg_level_r;
    end else if (reg_addr == `CEL_ADDR_P1_SW) begin
      rdata_nxt[`CEL_P_EN_BIT]   = p1_en_r;
      rdata_nxt[`CEL_P_MUTE_BIT] = p1_mute_r;
    end else if (reg_addr == `CEL_ADDR_P1_GAIN) begin
      rdata_nxt[`CEL_GAIN_HI:0] = p1_gain_r;
    end else if (reg_addr == `CEL_ADDR_P1_SRC) begin
      rdata_nxt[`CEL_SRC_HI:0] = p1_src_r;
    end else if (reg_addr == `CEL_ADDR_P2_SW) begin
      rdata_nxt[`CEL_P_EN_BIT]   = p2_en_r;
      rdata_nxt[`CEL_P_MUTE_BIT] = p2_mute_r;
    end else if (reg_addr == `CEL_ADDR_P2_GAIN) begin
      rdata_nxt[`CEL_GAIN_HI:0] = p2_gain_r;
    end else if (reg_addr == `CEL_ADDR_P2_SRC) begin
      rdata_nxt[`CEL_SRC_HI:0] = p2_src_r;
    end else if (reg_addr == `CEL_ADDR_FLAGS) begin
      rdata_nxt[`CEL_JACK_BIT] = jack_flag_r;
      rdata_nxt[`CEL_THR_BIT]  = thr_flag_r;
    end else if (reg_addr == `CEL_ADDR_MASKS) begin
      rdata_nxt[`CEL_JACK_BIT] = jack_mask_r;
      rdata_nxt[`CEL_THR_BIT]  = thr_mask_r;
    end
  end

  // Read data holds until the next read
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      reg_rdata_r <= `CEL_RST_BYTE;
    end else if (reg_rd && !wr_flags) begin
      reg_rdata_r <= rdata_nxt;
    end else if (reg_rd) begin
      reg_rdata_r <= rdata_nxt;
    end
  end

endmodule // cel_regs

/* verif/cel_regs_sva.sv */
// Checker on the register slice ports: field writes and the holding of the first preamp gain.
// Assumes binding onto cel_regs with one clock and an async reset.
`timescale 1ns/1ps
module cel_regs_sva (
  input wire       mclk,
  input wire       reset,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire [3:0] det_chan_en_r,
  input wire [6:0] det_threshold_r,
  input wire       pad_low_range_r,
  input wire       core_reg_en_r,
  input wire [1:0] core_reg_level_r,
  input wire       p1_en_r,
  input wire       p1_mute_r,
  input wire [2:0] p1_gain_r,
  input wire [1:0] p1_src_r,
  input wire       p2_en_r,
  input wire       p2_mute_r,
  input wire [2:0] p2_gain_r,
  input wire [1:0] p2_src_r
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // ==========================================
  // Field capture and hold
  property p_det_en; reg_wr && reg_addr == 8'h50 |=> det_chan_en_r == $past(reg_wdata[3:0]);
  endproperty
  a_det_en: assert property (p_det_en) else $error("detector enables not captured");
  property p_thr; reg_wr && reg_addr == 8'h51 |=> det_threshold_r == $past(reg_wdata[6:0]);
  endproperty
  a_thr: assert property (p_thr) else $error("threshold not captured");
  property p_pad; reg_wr && reg_addr == 8'hE0 |=> pad_low_range_r == $past(reg_wdata[0]);
  endproperty
  a_pad: assert property (p_pad) else $error("pad range not captured");
  property p_core; reg_wr && reg_addr == 8'hE1 ##1 1'b1 |-> core_reg_en_r == $past(reg_wdata[7]);
  endproperty
  a_core: assert property (p_core) else $error("regulator enable not captured");
  property p_lvl; reg_wr && reg_addr == 8'hE1 |=> core_reg_level_r == $past(reg_wdata[5:4]);
  endproperty
  a_lvl: assert property (p_lvl) else $error("regulator level not captured");
  property p_p1; reg_wr && reg_addr == 8'hB4 |=> {p1_en_r, p1_mute_r} == $past(reg_wdata[7:6]);
  endproperty
  a_p1: assert property (p_p1) else $error("preamp switches not captured");
  property p_p2; reg_wr && reg_addr == 8'hB8 |=> {p2_en_r, p2_mute_r} == $past(reg_wdata[7:6]);
  endproperty
  a_p2: assert property (p_p2) else $error("second preamp switches not captured");
  property p_p2_gain; reg_wr && reg_addr == 8'hB9 |=> p2_gain_r == $past(reg_wdata[2:0]);
  endproperty
  a_p2_gain: assert property (p_p2_gain) else $error("second preamp gain not captured");
  property p_p1_src; reg_wr && reg_addr == 8'hB7 |=> p1_src_r == $past(reg_wdata[1:0]);
  endproperty
  a_p1_src: assert property (p_p1_src) else $error("first preamp source not captured");
  // Gain must hold unless its own register is written
  property p_gain; !(reg_wr && reg_addr == 8'hB5) |=> $stable(p1_gain_r);
  endproperty
  a_gain: assert property (p_gain) else $error("preamp gain changed unwritten");
  property p_src; reg_wr && reg_addr == 8'hBB |=> p2_src_r == $past(reg_wdata[1:0]);
  endproperty
  a_src: assert property (p_src) else $error("preamp source not captured");
endmodule // cel_regs_sva
bind cel_regs cel_regs_sva cel_regs_sva_i (.mclk, .reset, .reg_addr, .reg_wdata, .reg_wr,
  .det_chan_en_r, .det_threshold_r, .pad_low_range_r, .core_reg_en_r, .core_reg_level_r,
  .p1_en_r, .p1_mute_r, .p1_gain_r, .p1_src_r, .p2_en_r, .p2_mute_r, .p2_gain_r, .p2_src_r);

/* verif/cel_regs_tb.sv */
// Self-checking bench for the event, level and preamplifier registers.
// Assumes cel_regs driven directly; the checker is bound separately.
`timescale 1ns/1ps
module cel_regs_tb;
  reg         mclk = 1'b0;
  reg         reset = 1'b1;
  reg  [7:0]  reg_addr = 8'h00;
  reg  [7:0]  reg_wdata = 8'h00;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg         jack_change = 1'b0;
  reg  [27:0] chan_level = 28'h0;
  wire [7:0]  rdata;
  wire        irq;
  integer     errors = 0;
  integer     n_checks = 0;
  integer     i;
  localparam [95:0] ADRS = {8'h50,8'h51,8'hB4,8'hB5,8'hB7,8'hB8,8'hB9,8'hBB,8'hE0,8'hE1,8'hED,8'hEE};
  localparam [95:0] RSTV = {8'h00,8'h7F,8'h40,8'h01,8'h00,8'h40,8'h01,8'h00,8'h00,8'h00,8'h00,8'h00};
  localparam [95:0] MSKV = {8'h0F,8'h7F,8'hC0,8'h07,8'h03,8'hC0,8'h07,8'h03,8'h01,8'hB0,8'h00,8'h81};
  always #12.5 mclk = ~mclk;
  cel_regs cel_regs_i (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(rdata), .jack_change(jack_change),
    .chan_level(chan_level), .interrupt_out_low_r(irq), .det_chan_en_r(), .det_threshold_r(),
    .pad_low_range_r(), .core_reg_en_r(), .core_reg_level_r(), .p1_en_r(), .p1_mute_r(),
    .p1_gain_r(), .p1_src_r(), .p2_en_r(), .p2_mute_r(), .p2_gain_r(), .p2_src_r());
  // ==========================================
  // Shared tasks; all start and end just after a rising edge
  task chk(input string nm, input [7:0] exp, input [7:0] got);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task tick; @(posedge mclk); #1; endtask
  task wr(input [7:0] a, input [7:0] d);
    reg_wr = 1'b1; reg_addr = a; reg_wdata = d; tick; reg_wr = 1'b0; tick;
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    reg_rd = 1'b1; reg_addr = a; tick; reg_rd = 1'b0; chk("read data", exp, rdata); tick;
  endtask
  task irq_is(input b); chk("irq", {7'h00, b}, {7'h00, irq}); endtask
  task stop_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task t_reset;
    for (i = 11; i >= 0; i = i - 1) rd(ADRS[8*i+:8], RSTV[8*i+:8]);
    irq_is(1'b1);
  endtask
  task t_rw; // Reserved bits must read back 0
    for (i = 11; i >= 0; i = i - 1) begin
      wr(ADRS[8*i+:8], 8'hFF);
      rd(ADRS[8*i+:8], MSKV[8*i+:8]);
    end
    wr(8'h52, 8'hFF);
    rd(8'h52, 8'h00);
  endtask
  task t_jack;
    wr(8'hEE, 8'h00);
    jack_change = 1'b1; tick; jack_change = 1'b0;
    irq_is(1'b0);
    rd(8'hED, 8'h80);
    wr(8'hEE, 8'h80); tick; irq_is(1'b1);
    wr(8'hEE, 8'h00); tick; irq_is(1'b0);
    wr(8'hED, 8'h80); tick; irq_is(1'b1);
    rd(8'hED, 8'h00);
  endtask
  task t_level; // Equal level must not trip; disabled channel ignored
    wr(8'h50, 8'h04); wr(8'h51, 8'h20);
    chan_level = {7'h00, 7'h20, 7'h00, 7'h7F}; tick; tick;
    rd(8'hED, 8'h00);
    chan_level[20:14] = 7'h21; tick;
    rd(8'hED, 8'h01);
    irq_is(1'b0);
    wr(8'hEE, 8'h01); tick; irq_is(1'b1);
    chan_level = 28'h0; tick;
    rd(8'hED, 8'h01);
    wr(8'hEE, 8'h00); wr(8'hED, 8'h01); tick;
    rd(8'hED, 8'h00);
    irq_is(1'b1);
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    #1 reset = 1'b0;
    t_reset;
    t_rw;
    t_jack;
    t_level;
    stop_test;
  end
endmodule // cel_regs_tb
